// ===== verification/sfpc_ctrl_test.sv
// self-checking bench of the serial flash command control
module sfpc_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] MFR   = 8'h3C;  // arbitrary value
  localparam logic [7:0] DEV   = 8'h96;  // arbitrary value
  localparam int         LIMIT = 60000;
  logic clk, rst_n, wp_n, prog_busy, cs_n, sck, si, hold_n, so_out, so_oe;
  logic prog_abort, standby, deep_sleep, ultra_sleep, write_enable_latch, reset_cmd_enable, wp_active;
  int   n_mismatch = 0;
  int   cmp_count  = 0;
  int   cycles     = 0;
  int   aborts     = 0;

  // ==========================================================
  // clock, hang ceiling and abort pulse count
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (prog_abort === 1'b1) aborts <= aborts + 1;
    if (cycles == LIMIT) begin
      n_mismatch++;
      test_done();
    end
  end

  sfpc_ctrl #(.MFR_CODE(MFR), .DEV_CODE(DEV)) dut_u (
    .clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n),
    .so_out(so_out), .so_oe(so_oe), .prog_busy(prog_busy), .prog_abort(prog_abort),
    .standby(standby), .deep_sleep(deep_sleep), .ultra_sleep(ultra_sleep),
    .write_enable_latch(write_enable_latch), .reset_cmd_enable(reset_cmd_enable), .wp_active(wp_active));
  sfpc_host_model host_u (
    .clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .so_out(so_out), .so_oe(so_oe));

  // ==========================================================
  // helpers
  task automatic ck(input string what, input logic [39:0] seen, input logic [39:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // state word: standby, deep, ultra, write latch, reset enable
  task automatic ck_st(input string what, input logic [4:0] exp);
    ck(what, {standby, deep_sleep, ultra_sleep, write_enable_latch, reset_cmd_enable}, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic cmd(input logic [15:0] d, input int n);
    host_u.xfer({d, 48'h0}, n, -1, 4);
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_id();
    host_u.xfer({8'h15, 56'h0}, 40, -1, 4);
    ck("id bytes", host_u.so_bits[55:40], {MFR, DEV});
    ck("id enable", host_u.oe_bits[63:24], {8'h00, 16'hFFFF, 16'h0000});
    host_u.xfer({8'h15, 56'h0}, 20, -1, 4);
    ck("id msb first", host_u.so_bits[55:52], MFR[7:4]);
    ck("id cut short", so_oe, 1'b0);
    host_u.set_idle(1'b1);
    host_u.xfer({8'h15, 56'h0}, 24, -1, 4);
    ck("id mode 3", host_u.so_bits[55:40], {MFR, DEV});
    ck("id mode 3 enable", host_u.oe_bits[63:40], 24'h00FFFF);
    host_u.set_idle(1'b0);
    $display("test id done");
  endtask

  task automatic t_deep();
    cmd(16'hB9FF, 12);
    tick(130);
    ck_st("deep off byte", 5'h10);
    cmd(16'hB900, 5);
    tick(130);
    ck_st("deep short", 5'h10);
    prog_busy <= 1'b1;
    cmd(16'hB900, 8);
    tick(130);
    ck_st("deep busy", 5'h00);
    prog_busy <= 1'b0;
    tick(130);
    ck_st("deep dropped", 5'h10);
    cmd(16'hB955, 16);  // reissued once idle, extra byte ignored
    tick(130);
    ck_st("deep entered", 5'h08);
    host_u.xfer({8'h15, 56'h0}, 32, -1, 4);
    ck("deep id", host_u.oe_bits[63:32], 32'h0);
    cmd(16'h7900, 8);
    cmd(16'hABFF, 12);
    tick(330);
    ck_st("deep kept", 5'h08);
    cmd(16'hAB12, 16);
    tick(330);
    ck_st("deep left", 5'h10);
    $display("test deep done");
  endtask

  task automatic t_ultra();
    cmd(16'h0600, 8);
    cmd(16'h3110, 16);
    cmd(16'h0600, 8);
    prog_busy <= 1'b1;
    cmd(16'h7900, 8);
    tick(130);
    ck_st("ultra busy", 5'h03);
    prog_busy <= 1'b0;
    cmd(16'h7900, 5);
    tick(130);
    ck_st("ultra short", 5'h13);
    cmd(16'h7900, 8);
    tick(130);
    ck("ultra in", {standby, deep_sleep, ultra_sleep}, 3'b001);
    cmd(16'hAB00, 8);  // select pulse with a dummy byte
    host_u.xfer({8'h15, 56'h0}, 24, -1, 4);
    ck("ultra early op", host_u.oe_bits[63:40], 24'h0);
    tick(2810);
    ck_st("ultra out", 5'h10);
    cmd(16'h7900, 8);
    tick(130);
    host_u.xfer({8'h15, 56'h0}, 24, -1, 4);
    ck("wake early op", host_u.oe_bits[63:40], 24'h0);
    tick(2810);
    ck_st("wake early", 5'h10);
    cmd(16'h7900, 8);
    tick(130);
    host_u.xfer({8'h06, 56'h0}, 8, -1, 2810);
    ck_st("wake late", 5'h12);
    $display("test ultra done");
  endtask

  task automatic t_hold();
    wp_n <= 1'b0;
    host_u.xfer({8'h15, 56'h0}, 24, 12, 4);
    ck("pause floats", host_u.pause_oe, 1'b0);
    ck("pause protect", wp_active, 1'b1);
    ck("pause bytes", host_u.so_bits[55:40], {MFR, DEV});
    wp_n <= 1'b1;
    host_u.xfer({8'h06, 56'h0}, 8, 8, 4);
    ck_st("pause release", 5'h10);
    $display("test hold done");
  endtask

  task automatic t_reset();
    prog_busy <= 1'b1;
    cmd(16'hF0D0, 16);
    tick(20);
    ck("reset disabled", aborts, 0);
    ck("abort idle", prog_abort, 1'b0);
    cmd(16'h0600, 8);
    cmd(16'h3110, 16);
    ck_st("reset enabled", 5'h01);
    cmd(16'hF0D0, 20);
    cmd(16'hF000, 8);
    cmd(16'hF0D1, 16);
    tick(20);
    ck("reset refused", aborts, 0);
    cmd(16'h0600, 8);
    cmd(16'hF0D0, 24);
    tick(8);
    ck("reset taken", aborts, 1);
    ck_st("reset keeps", 5'h01);
    prog_busy <= 1'b0;
    tick(1210);
    ck_st("reset idle", 5'h11);
    cmd(16'hF0D0, 16);
    tick(8);
    ck("reset no latch", aborts, 2);
    $display("test reset done");
  endtask

  // ==========================================================
  // main sequence
  initial begin
    rst_n     = 1'b0;
    wp_n      = 1'b1;
    prog_busy = 1'b0;
    tick(5);
    rst_n <= 1'b1;
    tick(6);
    ck_st("after reset", 5'h10);
    t_id();
    t_deep();
    t_ultra();
    t_hold();
    t_reset();
    test_done();
  end
endmodule // sfpc_ctrl_test

// ===== verification/sfpc_host_model.sv
// behavioural spi host facing the serial flash command control
module sfpc_host_model (
  // clock
  input  wire logic clk,
  // pins toward the device
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  output logic      hold_n,
  // serial out from the device
  input  wire logic so_out,
  input  wire logic so_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] so_bits;
  logic [63:0] oe_bits;
  logic        pause_oe;
  logic        sck_idle;  // clock level between frames: 0 mode 0, 1 mode 3

  // ==========================================================
  // pins idle: select released, clock low until set_idle parks it for mode 3
  initial begin
    cs_n   = 1'b1;
    sck    = 1'b0;
    si     = 1'b0;
    hold_n = 1'b1;
    sck_idle = 1'b0;
  end

  // park the clock for mode 0 or mode 3 while select is released
  task automatic set_idle(input logic hi);
    sck_idle = hi;
    sck      <= hi;
    tick(8);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // pause entered and left while sck is low; clocks in between are junk
  task automatic pause(input bit keep);
    hold_n <= 1'b0;
    tick(4);
    pause_oe = so_oe;
    repeat (8) begin
      sck <= 1'b1;
      si  <= ~si;
      tick(4);
      sck <= 1'b0;
      tick(4);
    end
    hold_n <= keep ? 1'b0 : 1'b1;
    tick(4);
  endtask

  // ==========================================================
  // one frame in mode 0 or 3; so is sampled mid high phase, clear of its update
  task automatic xfer(input logic [63:0] d, input int n, input int hold_at, input int lead);
    int i;
    cs_n <= 1'b0;
    tick(lead);
    for (i = 0; i < n; i++) begin
      sck <= 1'b0;
      if (i == hold_at) pause(1'b0);
      si <= d[63-i];
      tick(4);
      sck <= 1'b1;
      tick(2);
      so_bits[63-i] = so_out;
      oe_bits[63-i] = so_oe;
      tick(2);
    end
    sck <= sck_idle;  // mode 3 parks high, with no closing fall
    if (hold_at == n) pause(1'b1);
    tick(4);
    cs_n <= 1'b1;
    si   <= ~si;  // released line must not keep its last value
    tick(8);
    hold_n <= 1'b1;
  endtask
endmodule // sfpc_host_model

// ===== verilog/sfpc_cfg.svh
// constants of the serial flash power, hold and reset controller
`ifndef SFPC_CFG_SVH
`define SFPC_CFG_SVH
// ==========================================================
// clock
`define SFPC_CLK_MHZ 40
// ==========================================================
// opcodes and confirmation byte
`define SFPC_OP_LEGACY_ID 8'h15
`define SFPC_OP_DEEP 8'hB9
`define SFPC_OP_RESUME 8'hAB
`define SFPC_OP_ULTRA 8'h79
`define SFPC_OP_RESET 8'hF0
`define SFPC_RESET_CONFIRM 8'hD0
`define SFPC_OP_WR_STAT2 8'h31
`define SFPC_OP_WR_EN 8'h06
// ==========================================================
// field positions and reset values
`define SFPC_RESET_CMD_ENABLE_BIT 4
`define SFPC_WEL_RST 1'b0
`define SFPC_RESET_CMD_ENABLE_RST 1'b0
`define SFPC_ID_BITS 5'h10
// ==========================================================
// times in ns; counts round down, being longest times
`define SFPC_DEEP_SLEEP_ENTRY_TIME_NS 3000
`define SFPC_DEEP_SLEEP_RESUME_TIME_NS 8000
`define SFPC_ULTRA_SLEEP_ENTRY_TIME_NS 3000
`define SFPC_ULTRA_SLEEP_EXIT_TIME_NS 70000
`define SFPC_SOFT_RESET_TIME_NS 30000
`define SFPC_DEEP_ENTRY_CYC ((`SFPC_DEEP_SLEEP_ENTRY_TIME_NS * `SFPC_CLK_MHZ) / 1000)
`define SFPC_DEEP_RESUME_CYC ((`SFPC_DEEP_SLEEP_RESUME_TIME_NS * `SFPC_CLK_MHZ) / 1000)
`define SFPC_ULTRA_ENTRY_CYC ((`SFPC_ULTRA_SLEEP_ENTRY_TIME_NS * `SFPC_CLK_MHZ) / 1000)
`define SFPC_ULTRA_EXIT_CYC ((`SFPC_ULTRA_SLEEP_EXIT_TIME_NS * `SFPC_CLK_MHZ) / 1000)
`define SFPC_SOFT_RESET_CYC ((`SFPC_SOFT_RESET_TIME_NS * `SFPC_CLK_MHZ) / 1000)
`endif

// ===== verilog/sfpc_ctrl.sv
// serial flash command control: legacy id, sleep modes, hold, soft reset
`include "sfpc_cfg.svh"
module sfpc_ctrl
  import sfpc_pkg::*;
#(
  parameter int         TMR_W    = 12,
  parameter logic [7:0] MFR_CODE = 8'h5A,  // arbitrary value
  parameter logic [7:0] DEV_CODE = 8'hC3   // arbitrary value
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // serial pins
  input  wire logic cs_n,
  input  wire logic sck,
  input  wire logic si,
  input  wire logic hold_n,
  input  wire logic wp_n,
  output logic      so_out,
  output logic      so_oe,
  // array engine, same clock
  input  wire logic prog_busy,
  output logic      prog_abort,
  // status
  output logic      standby,
  output logic      deep_sleep,
  output logic      ultra_sleep,
  output logic      write_enable_latch,
  output logic      reset_cmd_enable,
  output logic      wp_active
);
  // ==========================================================
  // counts and checks
  localparam int EDPD_C = `SFPC_DEEP_ENTRY_CYC;
  localparam int RDPD_C = `SFPC_DEEP_RESUME_CYC;
  localparam int EUDPD_C = `SFPC_ULTRA_ENTRY_CYC;
  localparam int XUDPD_C = `SFPC_ULTRA_EXIT_CYC;
  localparam int SWRST_C = `SFPC_SOFT_RESET_CYC;
  localparam int EDPD_W = EDPD_C + 2;
  localparam int RDPD_W = RDPD_C + 2;
  localparam int EUDPD_W = EUDPD_C + 2;
  if (TMR_W < 1 || TMR_W > 31 || (1 << TMR_W) <= XUDPD_C || (1 << TMR_W) <= SWRST_C) begin : g_chk
    $error("TMR_W too small for the longest timed state");
  end
  // every check below runs on clk and rests while reset is held
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // pin synchroniser; s1 feeds s2 only
  sfpc_pins_t  pin_s1;
  sfpc_pins_t  pin_s2;
  logic        sck_d;
  logic        cs_d;
  logic        hold_reg;
  logic [2:0]  bit_reg;
  logic [1:0]  byte_reg;
  logic [6:0]  sh_reg;
  logic [7:0]  op_reg;
  logic [7:0]  data_reg;
  logic        ign_reg;
  logic [4:0]  id_cnt_reg;
  logic [15:0] id_sh_reg;
  logic        drive_reg;
  logic        so_reg;
  logic        so_oe_reg;
  sfpc_state_t st_reg;
  sfpc_state_t st_next;
  logic [TMR_W-1:0] tmr_reg;
  logic [TMR_W-1:0] tmr_next;
  logic        wel_reg;
  logic        reset_cmd_enable_reg;
  logic        abort_reg;
  logic        standby_reg;
  logic        deep_reg;
  logic        ultra_reg;
  logic        wp_reg;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_s1 <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1, wp_n: 1'b1};
      pin_s2 <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1, wp_n: 1'b1};
    end else begin
      pin_s1 <= '{cs_n: cs_n, sck: sck, si: si, hold_n: hold_n, wp_n: wp_n};
      pin_s2 <= pin_s1;
    end
  end
  // ==========================================================
  // edges and pause; pause moves only while the clock is low, and ends at select release
  wire cs_act   = ~pin_s2.cs_n;
  wire cs_fall  = cs_act & ~cs_d;
  wire cs_rise  = ~cs_act & cs_d;
  wire hold_nx  = cs_act & (pin_s2.sck ? hold_reg : ~pin_s2.hold_n);
  wire sck_rise = cs_act & ~hold_reg & pin_s2.sck & ~sck_d;
  wire sck_fall = cs_act & ~hold_reg & ~pin_s2.sck & sck_d;
  // ==========================================================
  // byte assembly, msb first
  wire       byte_done = sck_rise & (bit_reg == 3'h7);
  wire [7:0] new_byte  = {sh_reg, pin_s2.si};
  wire       on_bound  = (bit_reg == 3'h0);
  wire       one_byte  = (byte_reg != 2'h0);
  wire       two_byte  = byte_reg[1];
  wire       op_ok     = one_byte & on_bound;
  wire       awake     = (st_reg == ST_STANDBY) & ~ign_reg;
  wire       cmd_end   = cs_rise & ~hold_reg;
  wire       hold_abort = cs_rise & hold_reg;
  wire [1:0] byte_inc  = (byte_reg == 2'h3) ? 2'h3 : byte_reg + 2'h1;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sck_d <= 1'b0;
      cs_d <= 1'b0;
      hold_reg <= 1'b0;
      bit_reg <= 3'h0;
      byte_reg <= 2'h0;
      sh_reg <= 7'h00;
      op_reg <= 8'h00;
      data_reg <= 8'h00;
    end else begin
      sck_d <= pin_s2.sck;
      cs_d <= cs_act;
      hold_reg <= hold_nx;
      bit_reg <= cs_fall ? 3'h0 : (sck_rise ? bit_reg + 3'h1 : bit_reg);
      byte_reg <= cs_fall ? 2'h0 : (byte_done ? byte_inc : byte_reg);
      if (sck_rise) sh_reg <= new_byte[6:0];
      if (byte_done && byte_reg == 2'h0) op_reg <= new_byte;
      if (byte_done && byte_reg == 2'h1) data_reg <= new_byte;
    end
  end
  // ==========================================================
  // frames begun in a busy power state are ignored by the standby command decode and the legacy id
  wire ign_nx = cs_fall ? ~(st_reg inside {ST_STANDBY, ST_DEEP, ST_ULTRA}) :
                ((st_reg == ST_ULTRA_WAKE) & sck_rise) ? 1'b1 : ign_reg;
  always_ff @(posedge clk) begin
    if (!rst_n) ign_reg <= 1'b0;
    else ign_reg <= ign_nx;
  end
  // ==========================================================
  // command decode at select release; legacy id at the end of its opcode byte
  wire cmd_now    = awake & cmd_end;
  wire id_go      = awake & byte_done & (byte_reg == 2'h0) & (new_byte == `SFPC_OP_LEGACY_ID);
  wire deep_go    = cmd_now & (op_reg == `SFPC_OP_DEEP) & op_ok & ~prog_busy;
  wire ultra_go   = cmd_now & (op_reg == `SFPC_OP_ULTRA) & one_byte & ~prog_busy;
  wire rst_go     = cmd_now & (op_reg == `SFPC_OP_RESET) & two_byte & on_bound &
                    (data_reg == `SFPC_RESET_CONFIRM) & reset_cmd_enable_reg;
  wire resume_go  = (st_reg == ST_DEEP) & cmd_end & (op_reg == `SFPC_OP_RESUME) & op_ok;
  wire wren_go    = cmd_now & (op_reg == `SFPC_OP_WR_EN) & op_ok;
  wire wrs2_cmd   = cmd_now & (op_reg == `SFPC_OP_WR_STAT2) & one_byte;
  wire wrs2_go    = wrs2_cmd & two_byte & on_bound & wel_reg;
  // ==========================================================
  // power state machine with one shared timer
  wire tmr_zero = (tmr_reg == '0);
  wire [TMR_W-1:0] tmr_dec = tmr_reg - 1'b1;
  always_comb begin
    st_next = st_reg;
    tmr_next = tmr_zero ? tmr_reg : tmr_dec;
    unique case (st_reg)
      ST_STANDBY: begin
        if (deep_go) begin
          st_next = ST_DEEP_ENTER;
          tmr_next = TMR_W'(EDPD_C);
        end else if (ultra_go) begin
          st_next = ST_ULTRA_ENTER;
          tmr_next = TMR_W'(EUDPD_C);
        end else if (rst_go) begin
          st_next = ST_RESET_WAIT;
          tmr_next = TMR_W'(SWRST_C);
        end
      end
      ST_DEEP_ENTER: if (tmr_zero) st_next = ST_DEEP;
      ST_DEEP: begin
        if (resume_go) begin
          st_next = ST_DEEP_EXIT;
          tmr_next = TMR_W'(RDPD_C);
        end
      end
      ST_DEEP_EXIT: if (tmr_zero) st_next = ST_STANDBY;
      ST_ULTRA_ENTER: if (tmr_zero) st_next = ST_ULTRA;
      ST_ULTRA: begin
        if (cs_fall) begin
          st_next = ST_ULTRA_WAKE;
          tmr_next = TMR_W'(XUDPD_C);
        end
      end
      ST_ULTRA_WAKE: begin
        if (cs_rise) begin
          st_next = ST_ULTRA_EXIT;
          tmr_next = TMR_W'(XUDPD_C);
        end else if (tmr_zero) begin
          st_next = ST_STANDBY;
        end
      end
      ST_ULTRA_EXIT: if (tmr_zero) st_next = ST_STANDBY;
      ST_RESET_WAIT: if (tmr_zero) st_next = ST_STANDBY;
    endcase
  end
  // leaving ultra sleep restores power-on values
  wire ultra_done = (st_reg inside {ST_ULTRA_WAKE, ST_ULTRA_EXIT}) & (st_next == ST_STANDBY);
  wire wel_clr = rst_go | hold_abort | wrs2_cmd;
  wire wel_nx  = ultra_done ? `SFPC_WEL_RST : (wren_go ? 1'b1 : (wel_clr ? 1'b0 : wel_reg));
  wire reset_cmd_enable_nx = ultra_done ? `SFPC_RESET_CMD_ENABLE_RST : (wrs2_go ? data_reg[`SFPC_RESET_CMD_ENABLE_BIT] : reset_cmd_enable_reg);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= ST_STANDBY;
      tmr_reg <= '0;
      wel_reg <= `SFPC_WEL_RST;
      reset_cmd_enable_reg <= `SFPC_RESET_CMD_ENABLE_RST;
      abort_reg <= 1'b0;
      standby_reg <= 1'b0;
      deep_reg <= 1'b0;
      ultra_reg <= 1'b0;
      wp_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      tmr_reg <= tmr_next;
      wel_reg <= wel_nx;
      reset_cmd_enable_reg <= reset_cmd_enable_nx;
      abort_reg <= rst_go;
      standby_reg <= (st_next == ST_STANDBY) & ~cs_act & ~prog_busy;
      deep_reg <= (st_next == ST_DEEP);
      ultra_reg <= (st_next inside {ST_ULTRA, ST_ULTRA_WAKE});
      wp_reg <= ~pin_s2.wp_n;
    end
  end
  // ==========================================================
  // legacy id shifter; data changes on falling clock
  wire drive_nx = cs_act & (sck_fall ? (id_cnt_reg != 5'h00) : drive_reg);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      id_cnt_reg <= 5'h00;
      id_sh_reg <= 16'h0000;
      drive_reg <= 1'b0;
      so_reg <= 1'b0;
      so_oe_reg <= 1'b0;
    end else begin
      drive_reg <= drive_nx;
      so_oe_reg <= drive_nx & ~hold_nx;
      if (!cs_act) begin
        id_cnt_reg <= 5'h00;
      end else if (id_go) begin
        id_cnt_reg <= `SFPC_ID_BITS;
        id_sh_reg <= {MFR_CODE, DEV_CODE};
      end else if (sck_fall && id_cnt_reg != 5'h00) begin
        so_reg <= id_sh_reg[15];
        id_sh_reg <= {id_sh_reg[14:0], 1'b0};
        id_cnt_reg <= id_cnt_reg - 5'h01;
      end
    end
  end
  // ==========================================================
  // outputs
  assign so_out = so_reg;
  assign so_oe = so_oe_reg;
  assign prog_abort = abort_reg;
  assign standby = standby_reg;
  assign deep_sleep = deep_reg;
  assign ultra_sleep = ultra_reg;
  assign write_enable_latch = wel_reg;
  assign reset_cmd_enable = reset_cmd_enable_reg;
  assign wp_active = wp_reg;
  // ==========================================================
  // checks
  sequence s_deep_cmd;
    deep_go;
  endsequence
  sequence s_in_deep;
    ##[1:EDPD_W] (st_reg == ST_DEEP);
  endsequence
  a_id_load: assert property (id_go |=> id_cnt_reg == 5'h10)
    else $error("legacy id not loaded");
  a_id_float: assert property (!cs_act |=> !so_oe_reg)
    else $error("output driven without select");
  a_standby_lvl: assert property (st_reg == ST_STANDBY && !cs_act && !cs_d && !prog_busy |=> standby_reg)
    else $error("standby not shown");
  a_deep_entry: assert property (s_deep_cmd |-> s_in_deep)
    else $error("deep sleep not reached in time");
  a_deep_ignore: assert property (st_reg == ST_DEEP && !resume_go |=> st_reg == ST_DEEP)
    else $error("deep sleep left without resume");
  a_busy_ignore: assert property (prog_busy && st_reg == ST_STANDBY |=> !(st_reg inside {ST_DEEP_ENTER, ST_ULTRA_ENTER}))
    else $error("sleep entered while busy");
  a_deep_resume: assert property (resume_go |-> ##[1:RDPD_W] st_reg == ST_STANDBY)
    else $error("resume not done in time");
  a_ultra_entry: assert property (ultra_go |-> ##[1:EUDPD_W] st_reg == ST_ULTRA)
    else $error("ultra sleep not reached in time");
  a_ultra_regs: assert property (ultra_done |=> !wel_reg && !reset_cmd_enable_reg)
    else $error("registers not at defaults after ultra sleep");
  a_hold_float: assert property (hold_reg |-> !so_oe_reg)
    else $error("output driven while paused");
  a_hold_abort: assert property (hold_abort |=> !wel_reg && !prog_abort &&
                                 ($stable(st_reg) || !($past(st_reg) inside {ST_STANDBY, ST_DEEP})))
    else $error("paused release did not abort");
  a_reset_gate: assert property (prog_abort |-> $past(reset_cmd_enable_reg) && $past(st_reg) == ST_STANDBY)
    else $error("reset without enable");
  a_reset_keep: assert property (rst_go |=> !wel_reg && $stable(reset_cmd_enable_reg) && st_reg == ST_RESET_WAIT)
    else $error("reset altered reset enable");
endmodule  // sfpc_ctrl

// ===== verilog/sfpc_pkg.sv
// types of the serial flash power, hold and reset controller
package sfpc_pkg;
  // ==========================================================
  // pin sample carried through the synchroniser
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic hold_n;
    logic wp_n;
  } sfpc_pins_t;
  // ==========================================================
  // power state
  typedef enum logic [8:0] {
    ST_STANDBY     = 9'h001,
    ST_DEEP_ENTER  = 9'h002,
    ST_DEEP        = 9'h004,
    ST_DEEP_EXIT   = 9'h008,
    ST_ULTRA_ENTER = 9'h010,
    ST_ULTRA       = 9'h020,
    ST_ULTRA_WAKE  = 9'h040,
    ST_ULTRA_EXIT  = 9'h080,
    ST_RESET_WAIT  = 9'h100
  } sfpc_state_t;
endpackage
